// file: rtl/lsl_lamp_strap.sv
// status-lamp driver with strap capture and an apb register slave
// assumes pins are synchronous to pclk and pad pull-ups follow lamp_pullup_en
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
module lsl_lamp_strap
  import lsl_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = lsl_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [lsl_pkg::APB_AW-1:0]   paddr,
  input  wire logic [lsl_pkg::APB_DW-1:0]   pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic [lsl_pkg::APB_DW-1:0]        prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         link_up,
  input  wire logic                         speed_100,
  input  wire logic                         activity,
  input  wire logic                         link_activity_lamp_i,
  output logic                              link_activity_lamp_o,
  output logic                              link_activity_lamp_oe,
  input  wire logic                         speed_activity_lamp_i,
  output logic                              speed_activity_lamp_o,
  output logic                              speed_activity_lamp_oe,
  output logic                              lamp_pullup_en,
  output logic                              autoneg_enable,
  output logic                              speed_select_100,
  output logic                              adv_speed_100
);
  import lsl_pkg::*;

  lsl_strap_state_t strap_reg;
  logic             strap_done;
  logic             an_reg;
  logic             spd_reg;
  logic             adv_reg;
  logic [1:0]       lamp_mode_reg;
  logic             link_lamp_reg;
  logic             spd_lamp_reg;
  logic             act_active;
  logic             act_phase;
  logic             blink_low;
  logic             setup_ph;
  logic             wr_access;
  logic             hit;
  logic [APB_DW-1:0] rd_next;

  // byte address of a register index
  function automatic logic [APB_AW-1:0] reg_addr(input logic [4:0] idx);
    reg_addr = {{(APB_AW-7){1'b0}}, idx, 2'b00};
  endfunction

  // true when the bus address selects the given register
  function automatic logic sel_reg(input logic [APB_AW-1:0] a, input logic [4:0] idx);
    sel_reg = (a == reg_addr(idx));
  endfunction

  // activity stretcher and blink phase
  lsl_blinker #(
    .HALF_CYCLES (BLINK_CYCLES)
  ) u_blinker (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .act_i    (activity),
    .active_o (act_active),
    .phase_o  (act_phase)
  );

  assign blink_low = act_active & ~act_phase;

  // strap sequence: wait in reset, capture on first enabled edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg <= STRAP_WAIT;
    end else if (ce) begin
      case (strap_reg)
        STRAP_WAIT: strap_reg <= STRAP_RUN;
        STRAP_RUN:  strap_reg <= STRAP_RUN;
        default:    strap_reg <= STRAP_WAIT;
      endcase
    end
  end

  assign strap_done = (strap_reg == STRAP_RUN);

  // pads are inputs with pull-ups until straps are taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_pullup_en         <= 1'b1;
      link_activity_lamp_oe  <= 1'b0;
      speed_activity_lamp_oe <= 1'b0;
    end else if (ce && strap_reg == STRAP_WAIT) begin
      lamp_pullup_en         <= 1'b0;
      link_activity_lamp_oe  <= 1'b1;
      speed_activity_lamp_oe <= 1'b1;
    end
  end

  // apb phase decode
  assign setup_ph  = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign hit       = sel_reg(paddr, IDX_CTRL) || sel_reg(paddr, IDX_STAT) ||
                     sel_reg(paddr, IDX_ADV) || sel_reg(paddr, IDX_LAMP);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit;

  // control bits: strap capture first, then software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_reg  <= CTRL_AN_RST;
      spd_reg <= CTRL_SPD_RST;
    end else if (ce) begin
      if (strap_reg == STRAP_WAIT) begin
        an_reg  <= link_activity_lamp_i;
        spd_reg <= speed_activity_lamp_i;
      end else if (wr_access && sel_reg(paddr, IDX_CTRL) && pstrb[1]) begin
        an_reg  <= pwdata[CTRL_AN_BIT];
        spd_reg <= pwdata[CTRL_SPD_BIT];
      end
    end
  end

  // advertised speed capability follows the speed strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_reg <= CTRL_SPD_RST;
    end else if (ce) begin
      if (strap_reg == STRAP_WAIT) begin
        adv_reg <= speed_activity_lamp_i;
      end else if (wr_access && sel_reg(paddr, IDX_ADV) && pstrb[0]) begin
        adv_reg <= pwdata[ADV_SPD_BIT];
      end
    end
  end

  // shared lamp mode field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_mode_reg <= LAMP_MODE_RST;
    end else if (ce && wr_access && sel_reg(paddr, IDX_LAMP) && pstrb[0]) begin
      lamp_mode_reg <= pwdata[LAMP_HI:LAMP_LO];
    end
  end

  assign autoneg_enable   = an_reg;
  assign speed_select_100 = spd_reg;
  assign adv_speed_100    = adv_reg;

  // read mux
  always_comb begin
    rd_next = '0;
    if (sel_reg(paddr, IDX_CTRL)) begin
      rd_next[CTRL_AN_BIT]  = an_reg;
      rd_next[CTRL_SPD_BIT] = spd_reg;
    end else if (sel_reg(paddr, IDX_STAT)) begin
      rd_next[STAT_LINK_BIT] = link_up;
      rd_next[STAT_SPD_BIT]  = speed_100;
      rd_next[STAT_ACT_BIT]  = act_active;
      rd_next[STAT_DONE_BIT] = strap_done;
    end else if (sel_reg(paddr, IDX_ADV)) begin
      rd_next[ADV_SPD_BIT] = adv_reg;
    end else if (sel_reg(paddr, IDX_LAMP)) begin
      rd_next[LAMP_HI:LAMP_LO] = lamp_mode_reg;
    end
  end

  // read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && setup_ph && !pwrite) begin
      prdata <= rd_next;
    end
  end

  // link and activity lamp, high means off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_lamp_reg <= 1'b1;
    end else if (ce) begin
      case (lamp_mode_reg)
        LAMP_MODE_00: link_lamp_reg <= ~link_up | (link_up & blink_low);
        LAMP_MODE_01: link_lamp_reg <= ~link_up;
        default:      link_lamp_reg <= 1'b1;
      endcase
    end
  end

  // speed or activity lamp, high means off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_lamp_reg <= 1'b1;
    end else if (ce) begin
      case (lamp_mode_reg)
        LAMP_MODE_00: spd_lamp_reg <= ~speed_100;
        LAMP_MODE_01: spd_lamp_reg <= ~(act_active & act_phase);
        default:      spd_lamp_reg <= 1'b1;
      endcase
    end
  end

  assign link_activity_lamp_o  = link_lamp_reg;
  assign speed_activity_lamp_o = spd_lamp_reg;

  chk_oe_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !strap_done |-> (!link_activity_lamp_oe && !speed_activity_lamp_oe && lamp_pullup_en))
    else $error("lamp pins driven before strap capture");

  chk_oe_after_strap: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done |-> (link_activity_lamp_oe && speed_activity_lamp_oe && !lamp_pullup_en))
    else $error("lamp pins not driven after strap capture");

  chk_strap_autoneg: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done) |-> (autoneg_enable == $past(link_activity_lamp_i)))
    else $error("autoneg strap not latched from link lamp pin");

  chk_strap_speed: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done) |-> (speed_select_100 == $past(speed_activity_lamp_i)))
    else $error("speed strap not latched from speed lamp pin");

  chk_adv_speed: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done) |-> (adv_speed_100 == speed_select_100))
    else $error("advertised speed differs from speed strap");

  chk_link_only: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && strap_done && lamp_mode_reg == LAMP_MODE_01) |=> (link_activity_lamp_o == !$past(link_up)))
    else $error("link lamp does not follow link in mode 01");

  chk_nolink_off: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && lamp_mode_reg == LAMP_MODE_00 && !link_up) |=> link_activity_lamp_o)
    else $error("link lamp lit without link in mode 00");

  chk_speed_lamp: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && strap_done && lamp_mode_reg == LAMP_MODE_00) |=> (speed_activity_lamp_o == !$past(speed_100)))
    else $error("speed lamp does not follow speed in mode 00");

  chk_reserved_off: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && lamp_mode_reg[1]) |=> (link_activity_lamp_o && speed_activity_lamp_o))
    else $error("lamp lit in reserved mode");

  chk_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && wr_access && sel_reg(paddr, IDX_LAMP) && pstrb[0]) |=>
      (lamp_mode_reg == $past(pwdata[LAMP_HI:LAMP_LO])))
    else $error("lamp mode write not stored");

  chk_link_blink: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && strap_done && lamp_mode_reg == LAMP_MODE_00 && link_up) |=> (link_activity_lamp_o == $past(blink_low)))
    else $error("link lamp does not blink with activity in mode 00");

  chk_act_lamp: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && strap_done && lamp_mode_reg == LAMP_MODE_01) |=>
      (speed_activity_lamp_o == !$past(act_active && act_phase)))
    else $error("speed lamp does not show activity in mode 01");

  chk_lamps_dark_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !strap_done |-> (link_activity_lamp_o && speed_activity_lamp_o))
    else $error("lamp level left its reset value before strap capture");

  chk_pull_release: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done) |-> ($past(lamp_pullup_en) && !lamp_pullup_en))
    else $error("pad pull-ups not released at strap capture");

  chk_strap_once: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done |=> strap_done)
    else $error("strap capture repeated without a reset");

  chk_autoneg_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_done && !(wr_access && sel_reg(paddr, IDX_CTRL) && pstrb[1])) |=> $stable(autoneg_enable))
    else $error("autoneg strap value changed without a control write");

  chk_speed_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_done && !(wr_access && sel_reg(paddr, IDX_CTRL) && pstrb[1])) |=> $stable(speed_select_100))
    else $error("speed strap value changed without a control write");

endmodule

// file: rtl/lsl_pkg.sv
// constants for the status-lamp and strap block: register map, fields, modes, timing
// assumes a 100 MHz pclk and an APB master with 32-bit data
package lsl_pkg;

  // apb geometry
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STAT = 5'h01;
  localparam logic [4:0] IDX_ADV  = 5'h04;
  localparam logic [4:0] IDX_LAMP = 5'h1F;

  // control register fields
  localparam int unsigned CTRL_AN_BIT  = 12;
  localparam int unsigned CTRL_SPD_BIT = 13;

  // advertisement register field
  localparam int unsigned ADV_SPD_BIT = 7;

  // lamp configuration field
  localparam int unsigned LAMP_LO = 4;
  localparam int unsigned LAMP_HI = 5;

  // status register fields
  localparam int unsigned STAT_LINK_BIT = 0;
  localparam int unsigned STAT_SPD_BIT  = 1;
  localparam int unsigned STAT_ACT_BIT  = 2;
  localparam int unsigned STAT_DONE_BIT = 3;

  // lamp modes
  localparam logic [1:0] LAMP_MODE_00  = 2'h0;
  localparam logic [1:0] LAMP_MODE_01  = 2'h1;
  localparam logic [1:0] LAMP_MODE_RST = 2'h0;

  // reset values of software-visible bits before the straps land
  localparam logic       CTRL_AN_RST  = 1'h1;
  localparam logic       CTRL_SPD_RST = 1'h1;

  // timing: half period of the activity blink
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned BLINK_HALF_MS     = 40;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;

  // strap capture sequence
  typedef enum logic [0:0] {
    STRAP_WAIT,
    STRAP_RUN
  } lsl_strap_state_t;

endpackage

// file: rtl/lsl_blinker.sv
// activity stretcher and blink phase generator
// assumes act_i is a one-cycle or level activity indication synchronous to pclk
`timescale 1ns/100ps
module lsl_blinker #(
  parameter int unsigned HALF_CYCLES = 4000000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic act_i,
  output logic      active_o,
  output logic      phase_o
);
  localparam int unsigned HOLD = 2 * HALF_CYCLES;
  localparam int unsigned CW   = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_V = CW'(HOLD);
  localparam logic [CW-1:0] HALF_V = CW'(HALF_CYCLES);
  localparam logic [CW-1:0] ONE_V  = CW'(1);

  logic [CW-1:0] hold_reg;
  logic [CW-1:0] half_reg;

  // refuse blink periods the counters cannot serve
  if (HALF_CYCLES < 2) begin : g_bad_half
    $error("lsl_blinker: HALF_CYCLES must be at least 2");
  end

  // each activity event reloads a full blink of on-time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= '0;
    end else if (ce) begin
      if (act_i) begin
        hold_reg <= HOLD_V;
      end else if (hold_reg != '0) begin
        hold_reg <= hold_reg - ONE_V;
      end
    end
  end

  // phase flips every half period while stretched, rests at 1 when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg <= '0;
      phase_o  <= 1'b1;
    end else if (ce) begin
      if (hold_reg == '0 && !act_i) begin
        half_reg <= '0;
        phase_o  <= 1'b1;
      end else if (half_reg >= HALF_V - ONE_V) begin
        half_reg <= '0;
        phase_o  <= ~phase_o;
      end else begin
        half_reg <= half_reg + ONE_V;
      end
    end
  end

  assign active_o = (hold_reg != '0);

  chk_stretch_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && act_i) |=> (hold_reg == HOLD_V && active_o))
    else $error("activity did not reload the stretch counter");

endmodule

// file: verification/lsl_board.sv
// board model: strap resistors and status lamps on the two pins
// assumes pad enables from the lamp block; resistors beat the weak pad pull-ups
`timescale 1ns/100ps
module lsl_board (
  input  wire logic link_o,
  input  wire logic link_oe,
  input  wire logic spd_o,
  input  wire logic spd_oe,
  input  wire logic strap_link,
  input  wire logic strap_spd,
  output logic      link_pin,
  output logic      spd_pin
);
  // driven pin shows the driver, a released pin sits at its strap level
  assign link_pin = link_oe ? link_o : strap_link;
  assign spd_pin  = spd_oe ? spd_o : strap_spd;
endmodule

// file: verification/testbench.sv
// self-checking bench for the lamp and strap block
// assumes the board model on the lamp pins and a 100 MHz pclk
`timescale 1ns/100ps
module testbench;
  import lsl_pkg::*;
  localparam int unsigned BL = 4;
  logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              link_up, speed_100, activity, lk_i, lk_o, lk_oe, sp_i, sp_o, sp_oe;
  logic              pull, an, sel, adv, s_lk, s_sp;
  int                err_count, compares, seed, n;

  lsl_lamp_strap #(.BLINK_CYCLES(BL)) i_lsl_lamp_strap (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(link_up), .speed_100(speed_100),
    .activity(activity), .link_activity_lamp_i(lk_i), .link_activity_lamp_o(lk_o),
    .link_activity_lamp_oe(lk_oe), .speed_activity_lamp_i(sp_i), .speed_activity_lamp_o(sp_o),
    .speed_activity_lamp_oe(sp_oe), .lamp_pullup_en(pull), .autoneg_enable(an),
    .speed_select_100(sel), .adv_speed_100(adv));
  lsl_board i_lsl_board (.link_o(lk_o), .link_oe(lk_oe), .spd_o(sp_o), .spd_oe(sp_oe),
    .strap_link(s_lk), .strap_spd(s_sp), .link_pin(lk_i), .spd_pin(sp_i));

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset with given straps, then check capture
  task automatic do_reset(input logic l, input logic s);
    presetn <= 1'b0;
    s_lk <= l;
    s_sp <= s;
    repeat (8) @(posedge pclk);
    chk("oe in reset", 2'b00, {lk_oe, sp_oe});
    chk("pullup in reset", 1'b1, pull);
    chk("ctrl in reset", 2'b11, {an, sel});
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("oe after reset", 2'b11, {lk_oe, sp_oe});
    chk("pullup after reset", 1'b0, pull);
    chk("autoneg strap", l, an);
    chk("speed strap", {s, s}, {sel, adv});
    apb(1'b0, 12'h000, 0, 4'hF);
    chk("ctrl reg", {s, l}, rd[13:12]);
    apb(1'b0, 12'h010, 0, 4'hF);
    chk("adv reg", s, rd[7]);
  endtask

  function automatic logic [1:0] exp_lamp(input logic [1:0] md, input logic l, input logic s);
    case (md)
      2'b00: exp_lamp = {~l, ~s};
      2'b01: exp_lamp = {~l, 1'b1};
      default: exp_lamp = 2'b11;
    endcase
  endfunction

  // watchdog
  initial begin
    #200000;
    err_count++;
    conclude();
  end

  // main sequence
  initial begin
    seed = 32'hb50c;
    {presetn, ce, psel, penable, pwrite, link_up, speed_100, activity, s_lk, s_sp} = 10'b0100000011;
    {paddr, pwdata, pstrb} = '0;
    err_count = 0;
    compares = 0;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1], i[0]);
      $display("test strap %0d done", i);
    end
    apb(1'b0, 12'h008, 0, 4'hF);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 0, rd);
    n = $random(seed);
    apb(1'b1, 12'h000, 32'(n), 4'h1);
    apb(1'b0, 12'h000, 0, 4'hF);
    chk("ctrl lane off", 2'b11, rd[13:12]);
    apb(1'b1, 12'h000, 32'(n), 4'h2);
    apb(1'b0, 12'h000, 0, 4'hF);
    chk("ctrl written", {n[13], n[12]}, rd[13:12]);
    chk("ctrl outputs", {n[13], n[12]}, {sel, an});
    $display("test bus done");
    for (int md = 0; md < 4; md++) begin
      apb(1'b1, 12'(IDX_LAMP) << 2, 32'(md) << 4, 4'hF);
      apb(1'b0, 12'(IDX_LAMP) << 2, 0, 4'hF);
      chk("lamp mode", md[1:0], rd[5:4]);
      repeat (6) begin
        @(posedge pclk);
        {link_up, speed_100} <= 2'($random(seed));
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("lamps", exp_lamp(md[1:0], link_up, speed_100), {lk_o, sp_o});
      end
    end
    $display("test modes done");
    for (int md = 0; md < 2; md++) begin
      apb(1'b1, 12'(IDX_LAMP) << 2, 32'(md) << 4, 4'hF);
      link_up <= 1'b1;
      speed_100 <= 1'b1;
      activity <= 1'b1;
      @(posedge pclk);
      activity <= 1'b0;
      n = 0;
      repeat (3 * BL + 4) begin
        @(negedge pclk);
        n += (md == 0) ? lk_o : !sp_o;
      end
      chk("blink off cycles", BL, n);
    end
    $display("test blink done");
    // status word, adv write, then a low clock enable must freeze lamps and registers
    apb(1'b0, 12'(IDX_STAT) << 2, 0, 4'hF);
    chk("stat reg", 4'b1011, rd[3:0]);
    chk("mapped err", 1'b0, err);
    apb(1'b1, 12'(IDX_ADV) << 2, 0, 4'h1);
    apb(1'b0, 12'(IDX_ADV) << 2, 0, 4'hF);
    chk("adv written", 1'b0, rd[ADV_SPD_BIT]);
    chk("adv output", 1'b0, adv);
    @(posedge pclk);
    ce <= 1'b0;
    link_up <= 1'b0;
    activity <= 1'b1;
    apb(1'b1, 12'(IDX_LAMP) << 2, 32'h0000_0030, 4'hF);
    @(negedge pclk);
    chk("frozen lamps", 2'b01, {lk_o, sp_o});
    @(posedge pclk);
    ce <= 1'b1;
    activity <= 1'b0;
    apb(1'b1, 12'(IDX_LAMP) << 2, 32'h0000_0000, 4'hE);
    apb(1'b0, 12'(IDX_LAMP) << 2, 0, 4'hF);
    chk("mode kept", 2'b01, rd[5:4]);
    @(negedge pclk);
    chk("thawed lamps", 2'b11, {lk_o, sp_o});
    $display("test freeze done");
    conclude();
  end
endmodule
